// ---- logic/rtcc_pkg.sv ----
// register map, field layout and types of the counter and calendar block
package rtcc_pkg;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FLAGS = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_COUNT = 8'h10;
   localparam logic [7:0] OFS_PERIOD = 8'h14;
   localparam logic [7:0] OFS_COMPARE = 8'h18;

   localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
   localparam logic [15:0] PERIOD_RESET = 16'h0000;
   localparam logic [31:0] COMPARE_RESET = 32'h0000_0000;

   // control register bits
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_TWELVE = 2;
   localparam int CTRL_CLEAR_ON_MATCH = 3;
   localparam int CTRL_WPROT = 4;
   // flag and status register bits
   localparam int FLAG_MATCH = 0;
   localparam int FLAG_WRAP = 7;
   localparam int STATUS_BUSY = 0;

   // calendar field positions
   localparam int SEC_LSB = 0;
   localparam int MIN_LSB = 6;
   localparam int HOUR_LSB = 12;
   localparam int DAY_LSB = 17;
   localparam int MONTH_LSB = 22;
   localparam int YEAR_LSB = 26;
   localparam logic [5:0] SEC_MAX = 6'h3B;
   localparam logic [4:0] HOUR24_MAX = 5'h17;
   localparam logic [3:0] HOUR12_MAX = 4'hC;
   localparam logic [3:0] MONTH_MAX = 4'hC;

   // bus clock cycles taken to move a write into the counter logic
   localparam logic [3:0] SYNC_CYCLES = 4'h3;

   typedef enum logic [1:0] {
      counter32_mode,
      counter16_mode,
      calendar_mode,
      reserved_mode
   } rtcc_mode_t;

   typedef struct packed {
      logic write_protect;
      logic clear_on_match;
      logic twelve_hour_select;
      rtcc_mode_t mode;
   } rtcc_ctrl_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
   } rtcc_sync_req_t;
endpackage

// ---- logic/rtcc_regs.sv ----
// counter, calendar, period and compare registers behind an APB slave
// Operation
// RULE1 - 32-bit mode: counter is one 32-bit RW word at 0x10, reset zero
// RULE2 - 16-bit mode: counter is 16-bit RW at 0x10, reset zero
// RULE3 - counter writes are synchronized and refused under write protection
// RULE4 - calendar year is 6 bits at 31:26, offset from software year
// RULE5 - leap year when the two low year bits are zero
// RULE6 - month is 4 bits at 25:22, 1 is January, 12 December
// RULE7 - day is 5 bits at 21:17, 1 up to month length
// RULE8 - 24-hour form: hour bits 16:12 hold 0 to 23
// RULE9 - 12-hour form: low nibble 1 to 12, hour bit 4 is PM
// RULE10 - minute is 6 bits at 11:6, 0 to 59
// RULE11 - second is 6 bits at 5:0, 0 to 59
// RULE12 - 16-bit period at 0x14, protected, synchronized, reset zero
// RULE13 - 32-bit compare at 0x18; match sets compare flag next tick
// RULE14 - clear-on-match resets 32-bit counter on match, else keeps counting
// RULE15 - writing one clears a flag, writing zero leaves it
// RULE16 - overflow sets wrap flag on the next counter tick
// RULE17 - sync busy rises when a sync starts, falls when it completes
// RULE18 - 16-bit counter wraps to zero after period and flags wrap
// RULE19 - calendar carries seconds through minutes, hours, days, months, years
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module rtcc_regs
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic counter_tick,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic compare_match_flag,
   output logic wrap_flag,
   output logic sync_in_progress
);
   rtcc_pkg::rtcc_ctrl_t ctrl;
   rtcc_pkg::rtcc_sync_req_t pend;
   logic [31:0] count;
   logic [15:0] period_value;
   logic [31:0] compare_value_32;
   logic [3:0] sync_cnt;
   logic [31:0] next_count;
   logic [31:0] rd_val;
   logic access, wr_done, sync_reg, mapped, stall, apply;
   logic match32, wrap16, overflow32;

   function automatic logic [4:0] month_days(input logic [3:0] m,
                                             input logic leap);
      case (m)
         4'h2: month_days = leap ? 5'h1D : 5'h1C; // RULE5
         4'h4, 4'h6, 4'h9, 4'hB: month_days = 5'h1E;
         default: month_days = 5'h1F;
      endcase
   endfunction

   // one second step of the packed calendar word
   function automatic logic [31:0] cal_next(input logic [31:0] v,
                                            input logic twelve);
      logic [5:0] sec, mnt, yr;
      logic [4:0] hr, dy;
      logic [3:0] mo, lo;
      logic c;
      sec = v[rtcc_pkg::SEC_LSB +: 6]; // RULE11
      mnt = v[rtcc_pkg::MIN_LSB +: 6]; // RULE10
      hr = v[rtcc_pkg::HOUR_LSB +: 5];
      dy = v[rtcc_pkg::DAY_LSB +: 5]; // RULE7
      mo = v[rtcc_pkg::MONTH_LSB +: 4]; // RULE6
      yr = v[rtcc_pkg::YEAR_LSB +: 6]; // RULE4
      c = 1'b0;
      lo = hr[3:0];
      if (sec >= rtcc_pkg::SEC_MAX) // RULE19
      begin
         sec = 6'h00;
         c = 1'b1;
      end
      else
         sec = sec + 6'h01;
      if (c)
      begin
         c = (mnt >= rtcc_pkg::SEC_MAX);
         mnt = c ? 6'h00 : mnt + 6'h01;
      end
      if (c && !twelve) // RULE8
      begin
         c = (hr >= rtcc_pkg::HOUR24_MAX);
         hr = c ? 5'h00 : hr + 5'h01;
      end
      else if (c) // RULE9
      begin
         c = 1'b0;
         if (lo >= rtcc_pkg::HOUR12_MAX)
            lo = 4'h1;
         else if (lo == rtcc_pkg::HOUR12_MAX - 4'h1)
         begin
            lo = rtcc_pkg::HOUR12_MAX;
            c = hr[4];
            hr[4] = ~hr[4];
         end
         else
            lo = lo + 4'h1;
         hr[3:0] = lo;
      end
      if (c)
      begin
         c = (dy >= month_days(mo, yr[1:0] == 2'b00));
         dy = c ? 5'h01 : dy + 5'h01;
      end
      if (c)
      begin
         c = (mo >= rtcc_pkg::MONTH_MAX);
         mo = c ? 4'h1 : mo + 4'h1;
      end
      if (c)
         yr = yr + 6'h01;
      cal_next = {yr, mo, dy, hr, mnt, sec};
   endfunction

   assign access = psel & penable;
   assign wr_done = access & pready & pwrite;
   assign sync_reg = (paddr == rtcc_pkg::OFS_COUNT)
      || (paddr == rtcc_pkg::OFS_PERIOD)
      || (paddr == rtcc_pkg::OFS_COMPARE);
   assign mapped = sync_reg || (paddr == rtcc_pkg::OFS_CTRL)
      || (paddr == rtcc_pkg::OFS_FLAGS) || (paddr == rtcc_pkg::OFS_STATUS);
   // a synchronized write waits while an earlier one is in flight
   assign stall = sync_reg & pwrite & sync_in_progress;
   assign apply = sync_in_progress && (sync_cnt == 4'h0);
   assign match32 = (ctrl.mode == rtcc_pkg::counter32_mode)
      && (count == compare_value_32);
   assign wrap16 = (ctrl.mode == rtcc_pkg::counter16_mode)
      && (count[15:0] == period_value);
   assign overflow32 = (ctrl.mode == rtcc_pkg::counter32_mode)
      && (count == 32'hFFFF_FFFF);

   always_comb
   begin
      rd_val = 32'h0000_0000;
      case (paddr)
         rtcc_pkg::OFS_CTRL: rd_val[4:0] = ctrl;
         rtcc_pkg::OFS_FLAGS:
         begin
            rd_val[rtcc_pkg::FLAG_MATCH] = compare_match_flag;
            rd_val[rtcc_pkg::FLAG_WRAP] = wrap_flag;
         end
         rtcc_pkg::OFS_STATUS: rd_val[rtcc_pkg::STATUS_BUSY] = sync_in_progress;
         rtcc_pkg::OFS_COUNT:
            if (ctrl.mode == rtcc_pkg::counter16_mode)
               rd_val[15:0] = count[15:0]; // RULE2
            else
               rd_val = count; // RULE1
         rtcc_pkg::OFS_PERIOD: rd_val[15:0] = period_value;
         rtcc_pkg::OFS_COMPARE: rd_val = compare_value_32;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // bus answer one cycle into the access phase
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= access & ~pready & ~stall;
         pslverr <= access & ~pready & ~stall & ~mapped;
         prdata <= (access & ~pwrite & ~pready) ? rd_val : 32'h0000_0000;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         ctrl <= '0;
      else if (wr_done && paddr == rtcc_pkg::OFS_CTRL)
         ctrl <= pwdata[4:0];
   end

   // synchronized write path into the counter logic
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         sync_in_progress <= 1'b0;
         sync_cnt <= 4'h0;
         pend <= '0;
      end
      else if (wr_done && sync_reg && !ctrl.write_protect) // RULE3
      begin
         sync_in_progress <= 1'b1; // RULE17
         sync_cnt <= rtcc_pkg::SYNC_CYCLES - 4'h1;
         pend <= {paddr, pwdata};
      end
      else if (apply)
         sync_in_progress <= 1'b0; // RULE17
      else if (sync_in_progress)
         sync_cnt <= sync_cnt - 4'h1;
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         period_value <= rtcc_pkg::PERIOD_RESET;
         compare_value_32 <= rtcc_pkg::COMPARE_RESET;
      end
      else if (apply && pend.addr == rtcc_pkg::OFS_PERIOD)
         period_value <= pend.data[15:0]; // RULE12
      else if (apply && pend.addr == rtcc_pkg::OFS_COMPARE)
         compare_value_32 <= pend.data; // RULE13
   end

   always_comb
   begin
      next_count = count;
      case (ctrl.mode)
         rtcc_pkg::counter32_mode:
            if (match32 && ctrl.clear_on_match)
               next_count = 32'h0000_0000; // RULE14
            else
               next_count = count + 32'h0000_0001;
         rtcc_pkg::counter16_mode:
            if (wrap16)
               next_count = 32'h0000_0000; // RULE18
            else
               next_count = {16'h0000, count[15:0] + 16'h0001};
         rtcc_pkg::calendar_mode:
            next_count = cal_next(count, ctrl.twelve_hour_select); // RULE19
         default: next_count = count;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         count <= rtcc_pkg::COUNT_RESET; // RULE1 RULE2
      else if (apply && pend.addr == rtcc_pkg::OFS_COUNT)
         count <= pend.data; // RULE3
      else if (counter_tick)
         count <= next_count;
   end

   // flags: a set in the clearing cycle wins
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         compare_match_flag <= 1'b0;
         wrap_flag <= 1'b0;
      end
      else
      begin
         compare_match_flag <= (compare_match_flag & ~(wr_done
            && paddr == rtcc_pkg::OFS_FLAGS
            && pwdata[rtcc_pkg::FLAG_MATCH])) // RULE15
            | (counter_tick & match32); // RULE13
         wrap_flag <= (wrap_flag & ~(wr_done
            && paddr == rtcc_pkg::OFS_FLAGS
            && pwdata[rtcc_pkg::FLAG_WRAP])) // RULE15
            | (counter_tick & (wrap16 | overflow32)); // RULE16
      end
   end

   property p_reset_count;
      @(posedge mclk) !rstn |=> count == 32'h0000_0000;
   endproperty
   a_reset_count: assert property (p_reset_count) // RULE1
      else $error("counter not zero after reset");

   property p_match_flag;
      @(posedge mclk) disable iff (!rstn)
         counter_tick && match32 |=> compare_match_flag;
   endproperty
   a_match_flag: assert property (p_match_flag) // RULE13
      else $error("compare flag missed on match");

   property p_match_clear;
      @(posedge mclk) disable iff (!rstn)
         counter_tick && match32 && ctrl.clear_on_match && !apply
         |=> count == 32'h0000_0000;
   endproperty
   a_match_clear: assert property (p_match_clear) // RULE14
      else $error("counter not cleared on match");

   property p_match_run;
      @(posedge mclk) disable iff (!rstn)
         counter_tick && match32 && !ctrl.clear_on_match && !apply
         |=> count == $past(count) + 32'h0000_0001;
   endproperty
   a_match_run: assert property (p_match_run) // RULE14
      else $error("counter stopped on match without clear");

   property p_wrap16;
      @(posedge mclk) disable iff (!rstn)
         counter_tick && wrap16 && !apply
         |=> count == 32'h0000_0000 && wrap_flag;
   endproperty
   a_wrap16: assert property (p_wrap16) // RULE18
      else $error("16-bit counter did not wrap at period");

   property p_overflow32;
      @(posedge mclk) disable iff (!rstn)
         counter_tick && overflow32 |=> wrap_flag;
   endproperty
   a_overflow32: assert property (p_overflow32) // RULE16
      else $error("wrap flag missed on overflow");

   property p_sync_busy;
      @(posedge mclk) disable iff (!rstn)
         wr_done && sync_reg && !ctrl.write_protect
         |=> sync_in_progress [*3] ##1 !sync_in_progress;
   endproperty
   a_sync_busy: assert property (p_sync_busy) // RULE17
      else $error("sync busy window wrong length");

   property p_protect;
      @(posedge mclk) disable iff (!rstn)
         wr_done && sync_reg && ctrl.write_protect && !sync_in_progress
         |=> !sync_in_progress;
   endproperty
   a_protect: assert property (p_protect) // RULE3
      else $error("protected write started a sync");

   property p_w1c;
      @(posedge mclk) disable iff (!rstn)
         wr_done && paddr == rtcc_pkg::OFS_FLAGS
         && pwdata[rtcc_pkg::FLAG_WRAP] && !counter_tick
         |=> !wrap_flag;
   endproperty
   a_w1c: assert property (p_w1c) // RULE15
      else $error("wrap flag not cleared by one");

   property p_sec_roll;
      @(posedge mclk) disable iff (!rstn)
         counter_tick && ctrl.mode == rtcc_pkg::calendar_mode && !apply
         && count[5:0] == rtcc_pkg::SEC_MAX
         |=> count[5:0] == 6'd0 && count[11:6] != $past(count[11:6]);
   endproperty
   a_sec_roll: assert property (p_sec_roll) // RULE11
      else $error("seconds did not roll into minutes");

   property p_period_apply;
      @(posedge mclk) disable iff (!rstn)
         apply && pend.addr == rtcc_pkg::OFS_PERIOD
         |=> period_value == $past(pend.data[15:0]);
   endproperty
   a_period_apply: assert property (p_period_apply) // RULE12
      else $error("period not loaded after sync");
endmodule

// ---- verif/tb_top.sv ----
// self-checking testbench of the counter and calendar registers
`timescale 1ns/1ps
`define CHK(a, e) \
   begin \
      checked++; \
      if ((a) !== (e)) \
      begin \
         n_errors++; \
         $display("[FAIL] %0t got %h exp %h", $time, a, e); \
      end \
   end
module tb_top;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic counter_tick = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic compare_match_flag;
   logic wrap_flag;
   logic sync_in_progress;
   logic [31:0] q;
   logic err;
   logic [31:0] cb [7];
   logic [31:0] ca [7];
   logic [31:0] cc [7];
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;

   rtcc_regs DUT (
      .mclk(mclk),
      .rstn(rstn),
      .counter_tick(counter_tick),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .compare_match_flag(compare_match_flag),
      .wrap_flag(wrap_flag),
      .sync_in_progress(sync_in_progress)
   );

   always #5 mclk = ~mclk;

   task give_verdict;
      if (n_errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         give_verdict;
      end
   end

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 40);
      if (n >= 40)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, pready, 1'b1);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(q, e)
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   // busy must show right after the write, then clear within bound
   task wsync;
      int n;
      n = 0;
      @(posedge mclk);
      `CHK(sync_in_progress, 1'b1)
      while (sync_in_progress !== 1'b0 && n < 20)
      begin
         @(posedge mclk);
         n++;
      end
      `CHK(sync_in_progress, 1'b0)
   endtask

   // one count step per pulse, then room for the flags to land
   task tick(input int n);
      repeat (n)
      begin
         @(posedge mclk);
         counter_tick <= 1'b1;
         @(posedge mclk);
         counter_tick <= 1'b0;
      end
      repeat (2) @(posedge mclk);
   endtask

   function automatic logic [31:0] cal(input int y, input int mo,
      input int d, input int h, input int mi, input int s);
      return {6'(y), 4'(mo), 5'(d), 5'(h), 6'(mi), 6'(s)};
   endfunction

   initial
   begin
      cb = '{cal(3, 12, 31, 5'h17, 59, 59), cal(4, 2, 28, 5'h17, 59, 59),
         cal(5, 2, 28, 5'h17, 59, 59), cal(5, 4, 30, 5'h17, 59, 59),
         cal(1, 6, 15, 5'h0B, 59, 59), cal(1, 6, 15, 5'h1B, 59, 59),
         cal(1, 6, 16, 5'h0C, 59, 59)};
      ca = '{cal(4, 1, 1, 0, 0, 0), cal(4, 2, 29, 0, 0, 0),
         cal(5, 3, 1, 0, 0, 0), cal(5, 5, 1, 0, 0, 0),
         cal(1, 6, 15, 5'h1C, 0, 0), cal(1, 6, 16, 5'h0C, 0, 0),
         cal(1, 6, 16, 5'h01, 0, 0)};
      cc = '{32'h0000_0002, 32'h0000_0002, 32'h0000_0002, 32'h0000_0002,
         32'h0000_0006, 32'h0000_0006, 32'h0000_0006};
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      rd(8'h10, 32'h0000_0000);
      rd(8'h14, 32'h0000_0000);
      rd(8'h18, 32'h0000_0000);
      `CHK({compare_match_flag, wrap_flag}, 2'b00)
      wr(8'h18, 32'h0000_0003);
      wsync;
      rd(8'h18, 32'h0000_0003);
      tick(4);
      `CHK(compare_match_flag, 1'b1)
      rd(8'h10, 32'h0000_0004);
      wr(8'h08, 32'h0000_0000);
      `CHK(compare_match_flag, 1'b1)
      wr(8'h08, 32'h0000_0001);
      @(posedge mclk);
      `CHK(compare_match_flag, 1'b0)
      wr(8'h00, 32'h0000_0008);
      wr(8'h10, 32'h0000_0000);
      wsync;
      // 0,1,2,3 then cleared on match, then one more step
      tick(5);
      rd(8'h10, 32'h0000_0001);
      wr(8'h10, 32'hFFFF_FFFE);
      wsync;
      rd(8'h10, 32'hFFFF_FFFE);
      tick(2);
      `CHK(wrap_flag, 1'b1)
      rd(8'h10, 32'h0000_0000);
      wr(8'h08, 32'h0000_0080);
      @(posedge mclk);
      `CHK(wrap_flag, 1'b0)
      wr(8'h00, 32'h0000_0001);
      wr(8'h14, 32'h0000_0002);
      wsync;
      rd(8'h14, 32'h0000_0002);
      wr(8'h10, 32'hABCD_0001);
      wsync;
      rd(8'h10, 32'h0000_0001);
      tick(1);
      `CHK(wrap_flag, 1'b0)
      tick(1);
      rd(8'h10, 32'h0000_0000);
      `CHK(wrap_flag, 1'b1)
      wr(8'h00, 32'h0000_0011);
      wr(8'h10, 32'h0000_1234);
      @(posedge mclk);
      `CHK(sync_in_progress, 1'b0)
      rd(8'h10, 32'h0000_0000);
      rd(8'h20, 32'h0000_0000);
      `CHK(err, 1'b1)
      for (int i = 0; i < 7; i++)
      begin
         wr(8'h00, cc[i]);
         wr(8'h10, cb[i]);
         wsync;
         rd(8'h10, cb[i]);
         tick(1);
         rd(8'h10, ca[i]);
      end
      give_verdict;
   end
endmodule
